/* File: design/ddr4_seq_ctrl.sv */
// ddr4 command sequencing controller with per-constraint timers
// Summary of operation
// - after reset allow 1024 clocks of initial calibration first
// - long calibration blocks all commands for 512 clocks
// - short calibration blocks all commands for 128 clocks
// - after cke rises at reset exit wait max(5, refresh+10ns)
// - after self-refresh exit wait 4x refresh plus 10ns
// - after self-refresh exit hold dll commands for lock time
// - self-refresh cke low at least pulse plus one, plus parity
// - keep clock valid max(5,10ns) around entry and exit
// - cke pulse max(4,6ns); same wait after power-down exit
// - power-down lasts from pulse width up to nine refreshes
// - power-down entry 2 clocks after act, precharge, refresh
// - power-down entry read latency plus 5 after a read
// - power-down after writes waits latency, burst and recovery
// - per-device mode writes spaced max(16, 10ns)
// - power saving entry keeps clock for update plus disable
// - power saving exit: clock first, then exit delays
// - leveling: strobe driven after 25, first edge after 40
// - persistent parity: deselects issued soon after alert
// - mode register update delay max(24, 15ns)
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// down counter holding off commands until it reaches zero
// ------------------------------------------------------------
module ddr4_gap_timer
  import ddr4_seq_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset,
  input  wire logic  load,
  input  wire tcnt_t val,
  output logic       idle
);
  tcnt_t count;

  // keep the longer of what is pending and what is asked
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
    end else if (load && (val - T_ONE) > count) begin
      count <= val - T_ONE;
    end else if (count != '0) begin
      count <= count - T_ONE;
    end
  end

  assign idle = (count == '0);
endmodule : ddr4_gap_timer

// ------------------------------------------------------------
// top: request port in, device pins out
// ------------------------------------------------------------
module ddr4_seq_ctrl
  import ddr4_seq_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic req_valid,
  input  wire req_t req,
  input  wire cfg_t cfg,
  input  wire logic alert_n,
  output logic      req_ack,
  output dram_t     dram,
  output logic      ck_en,
  output logic      dqs_oe,
  output logic      dqs_edge_ok
);
  state_t state;
  logic   started;
  logic   exiting;
  logic   alert_m;
  logic   alert_s;
  logic   wl_on;
  tcnt_t  wl_cnt;
  tcnt_t  pd_left;
  logic   [NT-1:0] ld;
  logic   [NT-1:0] idle;
  tcnt_t  val [NT];
  logic   dll_op;
  logic   mrs_op;
  logic   exit_op;
  logic   go_idle;
  logic   go_exit;
  logic   take;
  logic   exit_start;
  logic   wake;
  logic   par_block;
  logic   pd_expire;
  logic   zq_init;
  tcnt_t  burst;

  // ------------------------------------------------------------
  // alert pin synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      alert_m <= 1'b1;
      alert_s <= 1'b1;
    end else begin
      alert_m <= alert_n;
      alert_s <= alert_m;
    end
  end

  // persistent mode: only deselects while alert is low
  assign par_block = cfg.par_persist && !alert_s;

  // ------------------------------------------------------------
  // request decode and gating
  // ------------------------------------------------------------
  always_comb begin
    dll_op = req.op inside {OP_RD, OP_RDA, OP_WR, OP_WRA};
    mrs_op = req.op inside {OP_MRS, OP_WLE, OP_MPE};
    exit_op = req.op inside {OP_SRX, OP_PDX, OP_MPX};
    go_idle = idle[TI_ALL] && !par_block && !exit_op
      && (req.op != OP_DES)
      && (!dll_op || idle[TI_DLL])
      && (mrs_op ? idle[TI_MRS] : idle[TI_MOD])
      && (!(req.op inside {OP_PDE, OP_SRE})
          || (idle[TI_PDE] && idle[TI_CKE]));
    go_exit = !exiting && idle[TI_CKE]
      && ((state == S_PD && req.op == OP_PDX)
       || (state == S_SR && req.op == OP_SRX)
       || (state == S_MP && req.op == OP_MPX));
    take = req_valid && !req_ack
      && ((state == S_IDLE && go_idle) || go_exit);
    pd_expire = state == S_PD && !exiting && pd_left == '0;
    exit_start = (take && go_exit) || pd_expire;
    wake = exiting && idle[TI_CK] && idle[TI_CKE];
    zq_init = state == S_ZQI && idle[TI_ALL];
    burst = cfg.bc4_fixed ? T_BURST_BC4 : T_BURST;
  end

  // ------------------------------------------------------------
  // timer loads
  // ------------------------------------------------------------
  always_comb begin
    ld = '0;
    for (int i = 0; i < NT; i++) begin
      val[i] = T_ONE;
    end
    // calibration and reset exit hold everything
    if (zq_init) begin
      ld[TI_ALL] = 1'b1;
      val[TI_ALL] = T_ZQINIT;
    end else if (state == S_RST && started && idle[TI_CK]) begin
      ld[TI_ALL] = 1'b1;
      val[TI_ALL] = T_XPR;
      ld[TI_CKE] = 1'b1;
      val[TI_CKE] = T_CKE;
    end else if (take && req.op == OP_ZQCL) begin
      ld[TI_ALL] = 1'b1;
      val[TI_ALL] = T_ZQOPER;
    end else if (take && req.op == OP_ZQCS) begin
      ld[TI_ALL] = 1'b1;
      val[TI_ALL] = T_ZQCS;
    end
    // exit delays by kind of low-power state
    if (wake) begin
      ld[TI_ALL] = 1'b1;
      ld[TI_DLL] = 1'b1;
      ld[TI_CKE] = 1'b1;
      val[TI_CKE] = T_CKE;
      case (state)
        S_PD: begin
          val[TI_ALL] = T_XP;
          val[TI_DLL] = T_XP;
        end
        S_SR: begin
          val[TI_ALL] = T_XS;
          val[TI_DLL] = T_DLLK;
        end
        default: begin
          val[TI_ALL] = T_XS;
          val[TI_DLL] = T_XMPDLL;
        end
      endcase
    end
    // mode register spacing and update delay
    if (take && mrs_op) begin
      ld[TI_MRS] = 1'b1;
      val[TI_MRS] = cfg.pda ? T_MRD_PDA : T_MRD;
      ld[TI_MOD] = 1'b1;
      val[TI_MOD] = T_MOD;
    end
    // spacing from a command to power-down entry
    if (take) begin
      ld[TI_PDE] = 1'b1;
      case (req.op)
        OP_ACT, OP_PRE, OP_PREA, OP_REF: val[TI_PDE] = T_PDEN;
        OP_RD, OP_RDA: val[TI_PDE] = T_RL + T_BURST + T_ONE;
        OP_WR: val[TI_PDE] = T_WL + burst + T_WR;
        OP_WRA: val[TI_PDE] = T_WL + burst + T_WR + T_ONE;
        default: ld[TI_PDE] = 1'b0;
      endcase
    end
    // cke pulse width and clock hold around entry and exit
    if (take && req.op == OP_PDE) begin
      ld[TI_CKE] = 1'b1;
      val[TI_CKE] = T_CKE;
    end
    if (take && req.op == OP_SRE) begin
      ld[TI_CKE] = 1'b1;
      val[TI_CKE] = T_CKESR + (cfg.par_en ? T_PL : '0);
    end
    if (take && req.op inside {OP_PDE, OP_SRE}) begin
      ld[TI_CK] = 1'b1;
      val[TI_CK] = T_CKSR + (cfg.par_en ? T_PL : '0);
    end else if (take && req.op == OP_MPE) begin
      ld[TI_CK] = 1'b1;
      val[TI_CK] = T_CKMPE;
    end else if (exit_start || (state == S_RST && !started)) begin
      ld[TI_CK] = 1'b1;
      val[TI_CK] = T_CKSR;
    end
  end

  // one timer for each spacing constraint
  for (genvar g = 0; g < NT; g++) begin : g_tmr
    ddr4_gap_timer u_tmr (
      .clk   (clk),
      .reset (reset),
      .load  (ld[g]),
      .val   (val[g]),
      .idle  (idle[g])
    );
  end

  // ------------------------------------------------------------
  // sequencing of state, cke, clock gate and command pins
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= S_RST;
      started <= 1'b0;
      exiting <= 1'b0;
      ck_en <= 1'b1;
      req_ack <= 1'b0;
      dram <= '{cke: 1'b0, cs_n: 1'b1, op: OP_DES, addr: '0};
    end else begin
      req_ack <= take;
      dram.op <= OP_DES;
      dram.cs_n <= 1'b1;
      if (take && !go_exit) begin
        dram.op <= req.op;
        dram.cs_n <= 1'b0;
        dram.addr <= req.addr;
      end
      case (state)
        S_RST: begin
          // clock runs before cke is raised
          if (!started) begin
            started <= 1'b1;
          end else if (idle[TI_CK]) begin
            dram.cke <= 1'b1;
            state <= S_ZQI;
          end
        end
        S_ZQI: begin
          if (idle[TI_ALL]) begin
            dram.op <= OP_ZQCL;
            dram.cs_n <= 1'b0;
            state <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (take && req.op == OP_PDE) begin
            dram.cke <= 1'b0;
            state <= S_PD;
          end else if (take && req.op == OP_SRE) begin
            dram.cke <= 1'b0;
            state <= S_SR;
          end else if (take && req.op == OP_MPE) begin
            state <= S_MP;
          end
        end
        S_PD, S_SR, S_MP: begin
          // clock stops only after the entry hold runs out
          if (exit_start) begin
            exiting <= 1'b1;
            ck_en <= 1'b1;
          end else if (wake) begin
            dram.cke <= 1'b1;
            exiting <= 1'b0;
            state <= S_IDLE;
          end else if (!exiting && idle[TI_CK]) begin
            ck_en <= 1'b0;
          end
        end
        default: state <= S_RST;
      endcase
    end
  end

  // ------------------------------------------------------------
  // power-down ceiling; auto exit avoids missed refreshes
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      pd_left <= '0;
    end else if (take && req.op == OP_PDE) begin
      // exit starts a clock hold early, so cke rises at the ceiling
      pd_left <= T_PD_MAX - T_CKSR - T_ONE;
    end else if (pd_left != '0) begin
      pd_left <= pd_left - T_ONE;
    end
  end

  // ------------------------------------------------------------
  // write leveling strobe enables
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      wl_on <= 1'b0;
      wl_cnt <= '0;
      dqs_oe <= 1'b0;
      dqs_edge_ok <= 1'b0;
    end else begin
      if (take && req.op == OP_WLE) begin
        wl_on <= 1'b1;
        wl_cnt <= '0;
      end else if (take && mrs_op) begin
        wl_on <= 1'b0;
      end else if (wl_cnt != T_WLMRD) begin
        wl_cnt <= wl_cnt + T_ONE;
      end
      dqs_oe <= wl_on && wl_cnt >= T_WLDQSEN - T_ONE;
      dqs_edge_ok <= wl_on && wl_cnt >= T_WLMRD - T_ONE;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic  issue;
  op_t   last_op;
  logic  last_init;
  logic  last_pda;
  tcnt_t gap;
  tcnt_t since_wl;

  assign issue = dram.op != OP_DES;

  // helper: clocks since the previous command and its kind
  always_ff @(posedge clk) begin
    if (reset) begin
      last_op <= OP_DES;
      last_init <= 1'b0;
      last_pda <= 1'b0;
      gap <= '0;
      since_wl <= '0;
    end else begin
      if (issue) begin
        last_op <= dram.op;
        last_init <= state == S_IDLE && last_op == OP_DES;
        last_pda <= cfg.pda;
        gap <= T_ONE;
      end else if (gap != '1) begin
        gap <= gap + T_ONE;
      end
      if (issue && dram.op == OP_WLE) begin
        since_wl <= T_ONE;
      end else if (since_wl != '1) begin
        since_wl <= since_wl + T_ONE;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_entry;
    $fell(dram.cke);
  endsequence
  sequence s_clock_held;
    ck_en [*5];
  endsequence

  a_zq_long: assert property (issue && last_op == OP_ZQCL
    |-> gap >= (last_init ? T_ZQINIT : T_ZQOPER))
    else $error("long calibration cut short");
  a_zq_short: assert property (issue && last_op == OP_ZQCS
    |-> gap >= T_ZQCS)
    else $error("short calibration cut short");
  a_pda_spacing: assert property (issue && dram.op == OP_MRS
    && last_op == OP_MRS && last_pda |-> gap >= T_MRD_PDA)
    else $error("mode writes too close in pda mode");
  a_cke_low: assert property (s_entry |-> !dram.cke [*4])
    else $error("cke low pulse too short");
  a_ck_after: assert property (s_entry |-> s_clock_held)
    else $error("clock stopped too soon after entry");
  a_ck_before: assert property ($rose(dram.cke) |-> $past(ck_en, 5))
    else $error("clock not valid before exit");
  a_read_pde: assert property (issue && dram.op == OP_PDE
    && last_op inside {OP_RD, OP_RDA} |-> gap >= T_RL + T_BURST + T_ONE)
    else $error("power-down too soon after read");
  a_wl_strobe: assert property (dqs_oe |-> since_wl >= T_WLDQSEN)
    else $error("strobe driven too early in leveling");
  a_wl_edge: assert property (dqs_edge_ok |-> since_wl >= T_WLMRD)
    else $error("first strobe edge too early");
  a_par_quiet: assert property (cfg.par_persist && !alert_n
    |-> ##2 (!take || !cfg.par_persist))
    else $error("command accepted while alert low");
endmodule : ddr4_seq_ctrl
`default_nettype wire

/* File: design/ddr4_seq_pkg.sv */
// constants and types for the ddr4 command sequencing controller
`default_nettype none
package ddr4_seq_pkg;
  typedef logic [10:0] tcnt_t;
  localparam int CK_NS = 50; // 20 MHz command clock
  // round a nanosecond limit up to whole clocks
  function automatic int cyc_up(input int ns);
    return (ns + CK_NS - 1) / CK_NS;
  endfunction : cyc_up
  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : imax
  // ------------------------------------------------------------
  // timing in its own units
  // ------------------------------------------------------------
  localparam int T_RFC1_NS = 260;
  localparam int T_RFC4_NS = 110;
  localparam int T_EXTRA_NS = 10;
  localparam int T_CKE_NS = 6;
  localparam int T_CKSR_NS = 10;
  localparam int T_MOD_NS = 15;
  localparam int T_PDA_NS = 10;
  localparam int T_WR_NS = 15;
  localparam int T_REFI_NS = 7800;
  // ------------------------------------------------------------
  // cycle counts
  // ------------------------------------------------------------
  localparam tcnt_t T_ZQINIT = 11'h400;
  localparam tcnt_t T_ZQOPER = 11'h200;
  localparam tcnt_t T_ZQCS = 11'h080;
  localparam tcnt_t T_XPR = 11'(imax(5, cyc_up(T_RFC1_NS + T_EXTRA_NS)));
  localparam tcnt_t T_XS = 11'(cyc_up(T_RFC4_NS + T_EXTRA_NS));
  localparam tcnt_t T_DLLK = 11'h300;
  localparam tcnt_t T_CKE = 11'(imax(4, cyc_up(T_CKE_NS)));
  localparam tcnt_t T_CKESR = 11'(T_CKE + 11'h001);
  localparam tcnt_t T_CKSR = 11'(imax(5, cyc_up(T_CKSR_NS)));
  localparam tcnt_t T_XP = T_CKE;
  localparam tcnt_t T_CPDED = 11'h004;
  localparam tcnt_t T_MOD = 11'(imax(24, cyc_up(T_MOD_NS)));
  localparam tcnt_t T_MRD = 11'h008;
  localparam tcnt_t T_MRD_PDA = 11'(imax(16, cyc_up(T_PDA_NS)));
  localparam tcnt_t T_CKMPE = 11'(T_MOD + T_CPDED);
  localparam tcnt_t T_XMPDLL = 11'(T_XS + T_DLLK);
  localparam tcnt_t T_PDEN = 11'h002;
  localparam tcnt_t T_RL = 11'h011; // programmed read latency
  localparam tcnt_t T_WL = 11'h00c; // programmed write latency
  localparam tcnt_t T_WR = 11'(cyc_up(T_WR_NS));
  localparam tcnt_t T_BURST = 11'h004;
  localparam tcnt_t T_BURST_BC4 = 11'h002;
  localparam tcnt_t T_PD_MAX = 11'(9 * T_REFI_NS / CK_NS);
  localparam tcnt_t T_WLDQSEN = 11'h019;
  localparam tcnt_t T_WLMRD = 11'h028;
  localparam tcnt_t T_PL = 11'h005;
  localparam tcnt_t T_ONE = 11'h001;
  // ------------------------------------------------------------
  // timer slots, one per constraint
  // ------------------------------------------------------------
  localparam int NT = 7;
  localparam int TI_ALL = 0;
  localparam int TI_DLL = 1;
  localparam int TI_MRS = 2;
  localparam int TI_MOD = 3;
  localparam int TI_PDE = 4;
  localparam int TI_CKE = 5;
  localparam int TI_CK = 6;
  typedef enum logic [4:0] {
    OP_DES, OP_ACT, OP_PRE, OP_PREA, OP_REF, OP_RD, OP_RDA,
    OP_WR, OP_WRA, OP_MRS, OP_ZQCL, OP_ZQCS, OP_SRE, OP_SRX,
    OP_PDE, OP_PDX, OP_MPE, OP_MPX, OP_WLE
  } op_t;
  typedef enum logic [5:0] {
    S_RST = 6'h01, S_ZQI = 6'h02, S_IDLE = 6'h04,
    S_PD = 6'h08, S_SR = 6'h10, S_MP = 6'h20
  } state_t;
  typedef struct packed {
    op_t op;
    logic [16:0] addr;
  } req_t;
  typedef struct packed {
    logic par_en;
    logic par_persist;
    logic pda;
    logic bc4_fixed;
  } cfg_t;
  typedef struct packed {
    logic cke;
    logic cs_n;
    op_t op;
    logic [16:0] addr;
  } dram_t;
endpackage : ddr4_seq_pkg
`default_nettype wire

/* File: verification/ddr4_dev_model.sv */
// behavioural ddr4 device facing the sequencing controller
`timescale 1ns/1ns
`default_nettype none
module ddr4_dev_model
  import ddr4_seq_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset,
  input  wire dram_t dram,
  input  wire logic  ck_en,
  input  wire logic  inj_par,
  input  wire logic  inj_crc,
  output logic       alert_n,
  output int         viol
);
  localparam int PAR_PW = 72; // shortest legal pulse at this grade
  localparam int CRC_PW = 8;
  logic cke_q, ck_q, in_lp, mp, entry, bad;
  int   cnt, dly, al_cnt;
  // ----------------
  // low-power tracking
  // ----------------
  assign entry = !dram.cs_n && (dram.op == OP_PDE || dram.op == OP_SRE
                                || dram.op == OP_MPE);
  // cnt counts cycles since entry; either wake edge ends the span
  always_ff @(posedge clk) begin
    cke_q <= dram.cke;
    ck_q  <= ck_en;
    if (reset || (dram.cke && !cke_q) || (ck_en && !ck_q)) begin
      in_lp <= 1'b0;
      cnt   <= 0;
    end else if (entry) begin
      in_lp <= 1'b1;
      mp    <= (dram.op == OP_MPE);
      cnt   <= 1;
    end else if (in_lp) begin
      cnt <= cnt + 1;
    end
  end
  // a command into a shut path, or the clock stopped too soon
  assign bad = (!dram.cs_n && (!ck_en || (in_lp && cnt >=
                 (mp ? int'(T_CKMPE) : int'(T_CPDED)))))
               || (in_lp && !ck_en
                   && cnt < (mp ? int'(T_CKMPE) : int'(T_CKSR)));
  always_ff @(posedge clk) begin
    if (reset) viol <= 0;
    else if (bad) viol <= viol + 1;
  end
  // ----------------
  // alert pin, released high by its pull-up
  // ----------------
  always_ff @(posedge clk) begin
    if (reset) begin
      dly    <= 0;
      al_cnt <= 0;
    end else if (inj_par) begin
      dly <= int'(T_PL);
    end else if (inj_crc) begin
      al_cnt <= CRC_PW;
    end else if (dly == 1) begin
      dly    <= 0;
      al_cnt <= PAR_PW;
    end else begin
      if (dly > 0) dly <= dly - 1;
      if (al_cnt > 0) al_cnt <= al_cnt - 1;
    end
  end
  assign alert_n = (al_cnt == 0);
endmodule : ddr4_dev_model
`default_nettype wire

/* File: verification/ddr4_seq_ctrl_tb.sv */
// self-checking bench for the ddr4 command sequencing controller
`timescale 1ns/1ns
`default_nettype none
module ddr4_seq_ctrl_tb
  import ddr4_seq_pkg::*;
;
  logic  clk, reset, req_valid, inj_par, inj_crc, alert_n, req_ack;
  logic  ck_en, dqs_oe, dqs_edge_ok, cke_q, ck_q, oe_q, ok_q;
  req_t  req;
  cfg_t  cfg;
  dram_t dram;
  int    viol, cyc, err_total, comparisons;
  int    t_up, t_dn, t_off, t_on, t_oe, t_ok;

  ddr4_seq_ctrl i_ddr4_seq_ctrl (
    .clk(clk), .reset(reset), .req_valid(req_valid), .req(req),
    .cfg(cfg), .alert_n(alert_n), .req_ack(req_ack), .dram(dram),
    .ck_en(ck_en), .dqs_oe(dqs_oe), .dqs_edge_ok(dqs_edge_ok));
  ddr4_dev_model i_ddr4_dev_model (
    .clk(clk), .reset(reset), .dram(dram), .ck_en(ck_en),
    .inj_par(inj_par), .inj_crc(inj_crc), .alert_n(alert_n), .viol(viol));

  // ----------------
  // clock and edge stamps
  // ----------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // stamps land at #2 so the main flow at #1 never races them
  always @(posedge clk) begin
    #2;
    if (dram.cke === 1'b1 && cke_q === 1'b0) t_up = cyc;
    if (dram.cke === 1'b0 && cke_q === 1'b1) t_dn = cyc;
    if (ck_en === 1'b0 && ck_q === 1'b1) t_off = cyc;
    if (ck_en === 1'b1 && ck_q === 1'b0) t_on = cyc;
    if (dqs_oe === 1'b1 && oe_q === 1'b0) t_oe = cyc;
    if (dqs_edge_ok === 1'b1 && ok_q === 1'b0) t_ok = cyc;
    cke_q = dram.cke;
    ck_q = ck_en;
    oe_q = dqs_oe;
    ok_q = dqs_edge_ok;
  end

  // ----------------
  // shared tasks
  // ----------------
  task automatic check_span(input string w, input int got, input int lo,
                            input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("wrong value %s expected %0d..%0d seen %0d", w, lo, hi, got);
    end
  endtask : check_span
  task automatic check_bit(input string w, input logic e, input logic got);
    comparisons++;
    if (got !== e) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", w, e, got);
    end
  endtask : check_bit
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic give_up(input string w);
    err_total++;
    $display("wrong value %s expected response seen none", w);
    report_and_stop();
  endtask : give_up
  // request stays up until acked; exit ops show a deselect on the pins
  task automatic wait_ack(input op_t o, output int t);
    int   n;
    logic ex;
    n = 0;
    ex = (o == OP_SRX || o == OP_PDX || o == OP_MPX);
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (req_ack !== 1'b1 && n < 3000);
    if (n >= 3000) give_up("request ack");
    t = cyc;
    check_bit("command pins", 1'b1,
              dram.op === (ex ? OP_DES : o) && dram.cs_n === ex);
    @(posedge clk);
    req_valid <= 1'b0;
  endtask : wait_ack
  task automatic issue(input op_t o, output int t);
    @(posedge clk);
    req_valid <= 1'b1;
    req.op <= o;
    req.addr <= {12'h0a5, o};
    wait_ack(o, t);
  endtask : issue

  // ----------------
  // scenarios
  // ----------------
  task automatic test_reset;
    int t, tz, tr, n;
    check_bit("cke in reset", 1'b0, dram.cke);
    check_bit("cs_n in reset", 1'b1, dram.cs_n);
    check_bit("ack in reset", 1'b0, req_ack);
    @(posedge clk);
    reset <= 1'b0;
    #1;
    tr = cyc;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (dram.op !== OP_ZQCL && n < 100);
    if (n >= 100) give_up("calibration start");
    tz = cyc;
    check_span("clock before cke", t_up - tr, T_CKSR, T_CKSR + 2);
    check_span("cke to calibration", tz - t_up, T_XPR, T_XPR + 2);
    issue(OP_ACT, t);
    check_span("init calibration", t - tz, T_ZQINIT, T_ZQINIT + 6);
    $display("test reset done");
  endtask : test_reset
  task automatic test_zq_mrs;
    int t0, t1, t2;
    issue(OP_ZQCS, t0);
    issue(OP_ACT, t1);
    check_span("short calibration", t1 - t0, T_ZQCS, T_ZQCS + 6);
    issue(OP_ZQCL, t0);
    issue(OP_PRE, t1);
    check_span("long calibration", t1 - t0, T_ZQOPER, T_ZQOPER + 6);
    cfg.pda <= 1'b1;
    issue(OP_MRS, t0);
    issue(OP_MRS, t1);
    check_span("pda mode spacing", t1 - t0, T_MRD_PDA, T_MRD_PDA + 6);
    issue(OP_ACT, t2);
    check_span("mode update", t2 - t1, T_MOD, T_MOD + 6);
    cfg.pda <= 1'b0;
    $display("test calibration and mode done");
  endtask : test_zq_mrs
  task automatic test_pd;
    int  t0, t1, t2, t3;
    op_t pre [9] = '{OP_ACT, OP_PRE, OP_PREA, OP_REF, OP_RD, OP_RDA,
                     OP_WR, OP_WRA, OP_WRA};
    int  gap [9] = '{T_PDEN, T_PDEN, T_PDEN, T_PDEN, T_RL + 5, T_RL + 5,
                     T_WL + 4 + T_WR, T_WL + 4 + T_WR + 1,
                     T_WL + 2 + T_WR + 1};
    for (int i = 0; i < 9; i++) begin
      cfg.bc4_fixed <= (i == 8);
      issue(pre[i], t0);
      issue(OP_PDE, t1);
      check_span("entry gap", t1 - t0, gap[i], gap[i] + 6);
      check_span("cke high width", t1 - t_up, T_CKE, 100000);
      repeat (8) @(posedge clk);
      issue(OP_PDX, t2);
      check_span("clock after entry", t_off - t1, T_CKSR, T_CKSR + 2);
      check_span("power-down length", t2 - t1, T_CKE, T_PD_MAX);
      issue(OP_ACT, t3);
      check_span("clock before exit", t_up - t_on, T_CKSR, T_CKSR + 2);
      check_span("exit to command", t3 - t_up, T_XP, T_XP + 4);
    end
    cfg.bc4_fixed <= 1'b0;
    $display("test power-down done");
  endtask : test_pd
  task automatic test_sr_mp;
    int t0, t1, t2;
    cfg.par_en <= 1'b1;
    issue(OP_SRE, t0);
    issue(OP_SRX, t1);
    issue(OP_ACT, t1);
    check_span("self refresh cke low", t_up - t_dn, T_CKESR + T_PL, 40);
    check_span("exit to plain command", t1 - t_up, T_XS, T_XS + 6);
    issue(OP_RD, t2);
    check_span("exit to dll command", t2 - t_up, T_DLLK, T_DLLK + 6);
    issue(OP_SRE, t0);
    repeat (16) @(posedge clk);
    issue(OP_SRX, t1);
    check_span("clock after entry", t_off - t0, T_CKSR + T_PL, T_CKSR + T_PL + 2);
    cfg.par_en <= 1'b0;
    issue(OP_MPE, t0);
    repeat (T_CKMPE + 4) @(posedge clk);
    check_span("clock after saving entry", t_off - t0, T_CKMPE, T_CKMPE + 2);
    issue(OP_MPX, t1);
    issue(OP_ACT, t2);
    check_span("saving exit plain", t2 - t1, T_CKSR + T_XS, T_CKSR + T_XS + 8);
    issue(OP_RD, t2);
    check_span("saving exit dll", t2 - t1, T_CKSR + T_XMPDLL, T_CKSR + T_XMPDLL + 8);
    $display("test self refresh and saving done");
  endtask : test_sr_mp
  task automatic test_alert;
    int t, n, bad;
    cfg.par_en <= 1'b1;
    cfg.par_persist <= 1'b1;
    @(posedge clk);
    inj_par <= 1'b1;
    @(posedge clk);
    inj_par <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (alert_n !== 1'b0 && n < 20);
    if (n >= 20) give_up("parity alert");
    repeat (3) @(posedge clk);
    req_valid <= 1'b1;
    req.op <= OP_ACT;
    bad = 0;
    repeat (60) begin
      @(posedge clk);
      #1;
      if (dram.cs_n !== 1'b1) bad++;
    end
    check_span("commands in alert", bad, 0, 0);
    wait_ack(OP_ACT, t);
    cfg.par_en <= 1'b0;
    cfg.par_persist <= 1'b0;
    @(posedge clk);
    inj_crc <= 1'b1;
    @(posedge clk);
    inj_crc <= 1'b0;
    #1;
    check_bit("crc alert", 1'b0, alert_n);
    issue(OP_PRE, t);
    $display("test alert done");
  endtask : test_alert
  task automatic test_wl;
    int t0;
    issue(OP_WLE, t0);
    repeat (T_WLMRD + 4) @(posedge clk);
    check_span("strobe drive", t_oe - t0, T_WLDQSEN, T_WLDQSEN + 2);
    check_span("first strobe edge", t_ok - t0, T_WLMRD, T_WLMRD + 2);
    $display("test leveling done");
  endtask : test_wl

  // ----------------
  // main sequence
  // ----------------
  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    cfg = '0;
    inj_par = 1'b0;
    inj_crc = 1'b0;
    {cyc, err_total, comparisons} = '0;
    {t_up, t_dn, t_off, t_on, t_oe, t_ok} = '0;
    {cke_q, ck_q, oe_q, ok_q} = 4'h4;
    repeat (20) @(posedge clk);
    #1;
    test_reset();
    test_zq_mrs();
    test_pd();
    test_sr_mp();
    test_alert();
    test_wl();
    check_span("device breaches", viol, 0, 0);
    report_and_stop();
  end
endmodule : ddr4_seq_ctrl_tb
`default_nettype wire
